// file: filter_setup_config.sv
/*
  Filter setup register for setup zero of a sigma-delta converter: storage,
  readback, mode decode, conversion abort/restart, postfilter settling timer and
  direct sinc3 word timer.
  Assumes the serial port decodes frames into one-cycle write and read strobes
  on i_clk, and the modulator clock arrives as a one-cycle enable pulse.
*/
`include "filter_setup_params.svh"

module filter_setup_config #(
  parameter int unsigned SETTLE_27_CYC = `SETTLE_27_US * `CLK_MHZ,
  parameter int unsigned SETTLE_21_CYC = `SETTLE_21_US * `CLK_MHZ,
  parameter int unsigned SETTLE_20_CYC = `SETTLE_20_US * `CLK_MHZ,
  parameter int unsigned SETTLE_16_CYC = `SETTLE_16_US * `CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire filter_setup_pkg::reg_addr_t i_reg_addr,
  input wire filter_setup_pkg::cfg_word_t i_reg_wdata,
  input wire logic i_mod_en,
  output filter_setup_pkg::cfg_word_t o_reg_rdata,
  output logic o_abort,
  output logic o_restart_seq,
  output logic o_direct_mode,
  output logic [14:0] o_decim_rate,
  output logic o_sinc3_path,
  output logic [1:0] o_order,
  output logic [4:0] o_rate_select,
  output logic o_pf_active,
  output logic [2:0] o_pf_choice,
  output logic o_pf_code_valid,
  output logic [15:0] o_pf_rate_sps100,
  output logic o_settling,
  output logic o_settle_done,
  output logic o_word_strobe
);
  import filter_setup_pkg::*;

  if (SETTLE_27_CYC < 1 || SETTLE_21_CYC < 1 || SETTLE_20_CYC < 1 || SETTLE_16_CYC < 1)
  begin : g_bad_settle
    $error("filter_setup_config: settling counts must be at least one cycle");
  end

  cfg_word_t cfg_reg;
  settle_state_t state_reg;
  logic [31:0] settle_cnt_reg;
  logic wr_hit;
  logic rd_hit;
  logic direct;
  logic pf_on;
  logic [2:0] pf_code;
  logic [31:0] settle_len;

  assign wr_hit = i_reg_wr && (i_reg_addr == `FSR_ADDR);
  assign rd_hit = i_reg_rd && (i_reg_addr == `FSR_ADDR);
  assign direct = cfg_reg[`FSR_DIRECT_BIT];
  assign pf_code = cfg_reg[`FSR_PF_MSB:`FSR_PF_LSB];
  // postfilter is ignored under direct decimation and outside sinc5+sinc1
  assign pf_on = !direct && cfg_reg[`FSR_PF_EN_BIT]
    && (cfg_reg[`FSR_ORDER_MSB:`FSR_ORDER_LSB] == `ORDER_SINC5_SINC1);

  always_comb
  begin
    case (pf_code)
      `PF_27: settle_len = SETTLE_27_CYC;
      `PF_21: settle_len = SETTLE_21_CYC;
      `PF_20: settle_len = SETTLE_20_CYC;
      `PF_16: settle_len = SETTLE_16_CYC;
      default: settle_len = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // register storage and readback
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_reg <= `FSR_RESET;
    end
    else if (wr_hit)
    begin
      // reserved bits are dropped so they always read back as zero
      cfg_reg <= i_reg_wdata & `FSR_WRITE_MASK;
    end
  end

  // unmapped reads return zero; no read holds the last answer
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_reg_rdata <= '0;
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= rd_hit ? cfg_reg : '0;
    end
  end

  // ----------------------------------------------------------------------------
  // conversion abort and sequence restart
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_abort <= 1'b0;
      o_restart_seq <= 1'b0;
    end
    else
    begin
      // every write to the filter setup address counts, even one that leaves the value unchanged
      o_abort <= wr_hit;
      o_restart_seq <= wr_hit;
    end
  end

  // ----------------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_direct_mode <= 1'b0;
      o_decim_rate <= '0;
      o_sinc3_path <= 1'b0;
      o_order <= `ORDER_SINC5_SINC1;
      o_rate_select <= '0;
      o_pf_active <= 1'b0;
      o_pf_choice <= `PF_20;
      o_pf_code_valid <= 1'b1;
      o_pf_rate_sps100 <= '0;
    end
    else
    begin
      o_direct_mode <= direct;
      o_decim_rate <= direct ? cfg_reg[`FSR_DECIM_MSB:0] : '0;
      o_sinc3_path <= direct
        || (cfg_reg[`FSR_ORDER_MSB:`FSR_ORDER_LSB] == `ORDER_SINC3);
      o_order <= direct ? `ORDER_SINC5_SINC1 : cfg_reg[`FSR_ORDER_MSB:`FSR_ORDER_LSB];
      o_rate_select <= direct ? '0 : cfg_reg[`FSR_RATE_MSB:`FSR_RATE_LSB];
      o_pf_active <= pf_on;
      o_pf_choice <= pf_code;
      // undefined codes are flagged rather than guessed at
      o_pf_code_valid <= (settle_len != 32'h0);
      case (pf_code)
        `PF_27: o_pf_rate_sps100 <= pf_on ? `SPS100_27 : '0;
        `PF_21: o_pf_rate_sps100 <= pf_on ? `SPS100_21 : '0;
        `PF_20: o_pf_rate_sps100 <= pf_on ? `SPS100_20 : '0;
        `PF_16: o_pf_rate_sps100 <= pf_on ? `SPS100_16 : '0;
        default: o_pf_rate_sps100 <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // postfilter settling timer, started by the abort that follows each write that leaves the postfilter on with a listed code
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_IDLE;
      settle_cnt_reg <= '0;
      o_settling <= 1'b0;
      o_settle_done <= 1'b0;
    end
    else
    begin
      o_settle_done <= 1'b0;
      if (o_abort)
      begin
        if (pf_on && settle_len != 32'h0)
        begin
          state_reg <= ST_SETTLE;
          settle_cnt_reg <= 32'(settle_len - 32'h1);
          o_settling <= 1'b1;
        end
        else
        begin
          state_reg <= ST_IDLE;
          o_settling <= 1'b0;
        end
      end
      else
      begin
        case (state_reg)
          ST_SETTLE:
          begin
            if (settle_cnt_reg == 32'h0)
            begin
              state_reg <= ST_IDLE;
              o_settling <= 1'b0;
              o_settle_done <= 1'b1;
            end
            else
            begin
              settle_cnt_reg <= 32'(settle_cnt_reg - 32'h1);
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // direct sinc3 word timing
  // ----------------------------------------------------------------------------
  word_timer #(
    .DECIM_W(15)
  ) u_word_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_run(direct && (cfg_reg[`FSR_DECIM_MSB:0] != 15'h0)),
    .i_restart(wr_hit),
    .i_mod_en(i_mod_en),
    .i_decim(cfg_reg[`FSR_DECIM_MSB:0]),
    .o_word(o_word_strobe)
  );

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  a_write_aborts: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_hit |=> o_abort && o_restart_seq)
    else $error("write did not abort conversion");
  a_abort_only_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_abort |-> $past(wr_hit))
    else $error("abort without register write");
  a_write_stores: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_hit |=> cfg_reg == ($past(i_reg_wdata) & 16'h8F7F))
    else $error("written value not stored");
  a_reserved_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_reg_rdata[14:12] == 3'h0)
    else $error("reserved bits 14..12 read nonzero");
  a_reserved_bit7: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_reg_rdata[7])
    else $error("reserved bit 7 reads nonzero");
  a_direct_override: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_direct_mode |-> !o_pf_active && o_rate_select == 5'h0 && o_sinc3_path)
    else $error("direct mode left other options active");
  a_pf_order_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_pf_active |-> o_order == 2'h0 && !o_sinc3_path)
    else $error("postfilter active outside sinc5+sinc1");
  a_pf_rate_27: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_pf_active && o_pf_choice == 3'h2) |-> o_pf_rate_sps100 == 16'h0A8C)
    else $error("wrong rate for code 010");
  a_pf_rate_20: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_pf_active && o_pf_choice == 3'h5) |-> o_pf_rate_sps100 == 16'h07D0)
    else $error("wrong rate for code 101");
  a_settle_end: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state_reg == ST_SETTLE && settle_cnt_reg == 32'h0 && !o_abort)
    |=> o_settle_done && !o_settling)
    else $error("settling did not end on count expiry");
  a_rate_field: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !direct |=> o_rate_select == $past(cfg_reg[4:0]))
    else $error("rate select not taken from rate field");
  c_write: cover property (@(posedge i_clk) disable iff (!i_rstn) wr_hit);
  c_settle_done: cover property (@(posedge i_clk) disable iff (!i_rstn) o_settle_done);
  c_direct: cover property (@(posedge i_clk) disable iff (!i_rstn) o_direct_mode);
endmodule : filter_setup_config

// file: filter_setup_params.svh
/*
  Named constants for the filter setup register block: address, reset value,
  field positions, postfilter codes, rates and settling times.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef FILTER_SETUP_PARAMS_SVH
`define FILTER_SETUP_PARAMS_SVH

// ----------------------------------------------------------------------------
// register address and layout
// ----------------------------------------------------------------------------
`define FSR_ADDR_W 6
`define FSR_ADDR 6'h28
`define FSR_W 16
`define FSR_RESET 16'h0500
// writable bits: 15, 11, 10:8, 6:0; reserved 14:12 and 7 stay zero
`define FSR_WRITE_MASK 16'h8F7F
`define FSR_DIRECT_BIT 15
`define FSR_DECIM_MSB 14
`define FSR_PF_EN_BIT 11
`define FSR_PF_MSB 10
`define FSR_PF_LSB 8
`define FSR_ORDER_MSB 6
`define FSR_ORDER_LSB 5
`define FSR_RATE_MSB 4
`define FSR_RATE_LSB 0

// ----------------------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------------------
`define ORDER_SINC5_SINC1 2'h0
`define ORDER_SINC3 2'h3
`define PF_27 3'h2
`define PF_21 3'h3
`define PF_20 3'h5
`define PF_16 3'h6

// ----------------------------------------------------------------------------
// rates (hundredths of a sample per second) and timing
// ----------------------------------------------------------------------------
`define SPS100_27 16'h0A8C
`define SPS100_21 16'h084D
`define SPS100_20 16'h07D0
`define SPS100_16 16'h0683
`define MOD_PER_DECIM 32
`define CLK_MHZ 40
`define SETTLE_27_US 36700
`define SETTLE_21_US 40000
`define SETTLE_20_US 50000
`define SETTLE_16_US 60000

`endif

// file: filter_setup_pkg.sv
/*
  Types shared by the filter setup register block.
  Assumes filter_setup_params.svh is on the include path.
*/
`include "filter_setup_params.svh"

package filter_setup_pkg;
  typedef logic [`FSR_W-1:0] cfg_word_t;
  typedef logic [`FSR_ADDR_W-1:0] reg_addr_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SETTLE = 1'b1
  } settle_state_t;
endpackage : filter_setup_pkg

// file: test_filter_setup_config.sv
/*
  Self-checking bench for filter_setup_config: register access, abort pulse,
  decode, postfilter settling and direct sinc3 word timing.
  Assumes the package and design files are compiled before it.
*/
`include "filter_setup_params.svh"

module test_filter_setup_config;
  timeunit 1ns;
  timeprecision 100ps;
  import filter_setup_pkg::*;

  // ----------------------------------------------------------------------
  // design under test, with short settling counts to keep the run brief
  // ----------------------------------------------------------------------
  localparam int unsigned L27 = 20;
  localparam int unsigned L21 = 30;
  localparam int unsigned L20 = 40;
  localparam int unsigned L16 = 50;
  logic i_clk;
  logic i_rstn;
  logic i_reg_wr;
  logic i_reg_rd;
  reg_addr_t i_reg_addr;
  cfg_word_t i_reg_wdata;
  logic i_mod_en;
  cfg_word_t o_reg_rdata;
  logic o_abort;
  logic o_restart_seq;
  logic o_direct_mode;
  logic [14:0] o_decim_rate;
  logic o_sinc3_path;
  logic [1:0] o_order;
  logic [4:0] o_rate_select;
  logic o_pf_active;
  logic [2:0] o_pf_choice;
  logic o_pf_code_valid;
  logic [15:0] o_pf_rate_sps100;
  logic o_settling;
  logic o_settle_done;
  logic o_word_strobe;
  int n_errors = 0;
  int n_compared = 0;

  filter_setup_config #(
    .SETTLE_27_CYC(L27),
    .SETTLE_21_CYC(L21),
    .SETTLE_20_CYC(L20),
    .SETTLE_16_CYC(L16)
  ) i_filter_setup_config (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_mod_en(i_mod_en),
    .o_reg_rdata(o_reg_rdata), .o_abort(o_abort), .o_restart_seq(o_restart_seq),
    .o_direct_mode(o_direct_mode), .o_decim_rate(o_decim_rate),
    .o_sinc3_path(o_sinc3_path), .o_order(o_order), .o_rate_select(o_rate_select),
    .o_pf_active(o_pf_active), .o_pf_choice(o_pf_choice),
    .o_pf_code_valid(o_pf_code_valid), .o_pf_rate_sps100(o_pf_rate_sps100),
    .o_settling(o_settling), .o_settle_done(o_settle_done),
    .o_word_strobe(o_word_strobe)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // returns {abort, restart} seen in the cycle after the strobe
  task automatic reg_write(input reg_addr_t addr, input cfg_word_t data,
                           output logic [1:0] pulses);
    i_reg_wr = 1'b1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    step();
    i_reg_wr = 1'b0;
    pulses = {o_abort, o_restart_seq};
    step();
  endtask : reg_write

  task automatic reg_read(input reg_addr_t addr, output cfg_word_t data);
    i_reg_rd = 1'b1;
    i_reg_addr = addr;
    step();
    i_reg_rd = 1'b0;
    data = o_reg_rdata;
    // let an edge pass so a following read does not lower and raise the strobe at once
    step();
  endtask : reg_read

  // counts cycles of settling; a bound keeps a stuck flag from hanging
  task automatic settle_len(output int cnt);
    cnt = 0;
    while (o_settling === 1'b1 && cnt < 200)
    begin
      cnt++;
      step();
    end
    if (cnt >= 200)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : settle_len

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    cfg_word_t d;
    reg_read(6'h28, d);
    check(d, 16'h0500);
    check(o_pf_choice, 16'h0005);
    check({o_pf_code_valid, o_pf_active, o_direct_mode}, 16'h0004);
    check(o_order, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_reserved();
    cfg_word_t d;
    logic [1:0] p;
    // the host keeps reserved bits at zero and uses a listed postfilter code
    reg_write(6'h28, 16'h8B7F, p);
    check(p, 16'h0003);
    check(o_abort, 16'h0000);
    reg_read(6'h28, d);
    check(d, 16'h8B7F);
    check({o_direct_mode, o_sinc3_path, o_pf_active}, 16'h0006);
    check(o_decim_rate, 16'h0B7F);
    check(o_rate_select, 16'h0000);
    $display("test reserved bits done");
  endtask : t_reserved

  task automatic t_unmapped();
    cfg_word_t d;
    logic [1:0] p;
    reg_write(6'h29, 16'h0000, p);
    check(p, 16'h0000);
    reg_read(6'h28, d);
    check(d, 16'h8B7F);
    reg_read(6'h29, d);
    check(d, 16'h0000);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_postfilter();
    logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    logic [15:0] rates [4] = '{16'h0A8C, 16'h084D, 16'h07D0, 16'h0683};
    int lens [4] = '{L27, L21, L20, L16};
    logic [1:0] p;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      reg_write(6'h28, {5'h01, codes[i], 8'h0A}, p);
      check({o_pf_active, o_pf_code_valid, o_settling}, 16'h0007);
      check(o_pf_rate_sps100, rates[i]);
      check(o_rate_select, 16'h000A);
      settle_len(n);
      check(16'(n), 16'(lens[i]));
      check(o_settle_done, 16'h0001);
    end
    $display("test postfilter codes done");
  endtask : t_postfilter

  task automatic t_order();
    logic [1:0] p;
    reg_write(6'h28, 16'h0D60, p);
    check({o_pf_active, o_sinc3_path, o_settling}, 16'h0002);
    check(o_order, 16'h0003);
    reg_write(6'h28, 16'h0213, p);
    check({o_sinc3_path, o_order}, 16'h0000);
    check(o_rate_select, 16'h0013);
    // enabled postfilter under direct decimation must stay idle
    reg_write(6'h28, 16'h8A00, p);
    check({o_pf_code_valid, o_settling}, 16'h0002);
    check(o_pf_rate_sps100, 16'h0000);
    $display("test order and direct override done");
  endtask : t_order

  // a second write in mid-settling restarts the full settling count
  task automatic t_abort_settle();
    logic [1:0] p;
    int n;
    reg_write(6'h28, 16'h0D00, p);
    repeat (5) step();
    reg_write(6'h28, 16'h0D00, p);
    check(p, 16'h0003);
    settle_len(n);
    check(16'(n), 16'(L20));
    $display("test abort during settling done");
  endtask : t_abort_settle

  task automatic t_direct();
    logic [1:0] p;
    int np;
    for (int n = 0; n < 3; n++)
    begin
      reg_write(6'h28, 16'h8000 | 16'(n), p);
      np = (n == 0) ? 40 : 32 * n;
      for (int i = 0; i < np; i++)
      begin
        i_mod_en = 1'b1;
        step();
        i_mod_en = 1'b0;
        check(o_word_strobe, (n != 0 && i == np - 1));
        step();
      end
    end
    $display("test direct word rate done");
  endtask : t_direct

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    i_rstn = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 6'h00;
    i_reg_wdata = 16'h0000;
    i_mod_en = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    step();
    t_reset();
    t_reserved();
    t_unmapped();
    t_postfilter();
    t_order();
    t_abort_settle();
    t_direct();
    print_verdict();
  end
endmodule : test_filter_setup_config

// file: word_timer.sv
/*
  Output word timer for direct sinc3 decimation: one word every
  32 x decimation modulator clock pulses.
  Assumes i_mod_en is a one-cycle pulse on i_clk and i_restart a one-cycle pulse.
*/
`include "filter_setup_params.svh"

module word_timer #(
  parameter int unsigned DECIM_W = 15
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic i_mod_en,
  input wire logic [DECIM_W-1:0] i_decim,
  output logic o_word
);
  localparam int unsigned CNT_W = DECIM_W + 5;

  if (DECIM_W < 1 || DECIM_W > 26)
  begin : g_bad_width
    $error("word_timer: unsupported decimation width");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(CNT_W'(i_decim) * CNT_W'(`MOD_PER_DECIM) - CNT_W'(1));

  // ----------------------------------------------------------------------------
  // modulator pulse counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_reg <= '0;
      o_word <= 1'b0;
    end
    else
    begin
      o_word <= 1'b0;
      if (i_restart || !i_run)
      begin
        cnt_reg <= '0;
      end
      else if (i_mod_en)
      begin
        if (cnt_reg >= limit)
        begin
          cnt_reg <= '0;
          o_word <= 1'b1;
        end
        else
        begin
          cnt_reg <= CNT_W'(cnt_reg + CNT_W'(1));
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  a_word_period: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run && !i_restart && i_mod_en && cnt_reg == limit) |=> o_word)
    else $error("word strobe missing at end of decimation period");
  a_word_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_mod_en || i_restart || !i_run) |=> !o_word)
    else $error("word strobe without modulator pulse");
  c_word: cover property (@(posedge i_clk) disable iff (!i_rstn) o_word);
endmodule : word_timer
